// ===== src/native_max_regs.svh
// Constants for the native maximum address query block
`ifndef NATIVE_MAX_REGS_SVH
`define NATIVE_MAX_REGS_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_NATIVE_MAX_28 8'hf8
`define CMD_NATIVE_MAX_48 8'h27

// ****************************************
// Limits and field positions
// ****************************************
`define LBA28_SATURATED 28'hfffffff
`define LBA28_LIMIT 48'h00000fffffff
`define DEVHEAD_LBA_BIT 6
`define ERR_ABORT_BIT 2
`define ST_BUSY_BIT 7
`define ST_READY_BIT 6
`define ST_FAULT_BIT 5
`define ST_DATA_REQUEST_BIT 3
`define ST_ERROR_BIT 0
`define STATUS_RESET 8'h40
`define ERROR_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define BUSY_TIME_NS 20
`define CLK_PERIOD_NS 5
`define BUSY_CYCLES ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/native_max_pkg.sv
// Types for the native maximum address query block
package native_max_pkg;

  typedef struct packed {
    logic [7:0] sector_number;
    logic [7:0] cylinder_low;
    logic [7:0] cylinder_high;
    logic [3:0] head;
  } task_file_out_t;

  typedef struct packed {
    logic [15:0] cylinders;
    logic [3:0] heads;
    logic [7:0] sectors;
  } chs_geometry_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } query_state_t;

endpackage

// ===== src/native_max_address_query.sv
// Native maximum address query command handler
`timescale 1ns/1ps
`include "native_max_regs.svh"

// How it works
// - Command code f8 is decoded as the 28-bit native maximum query.
// - Command code 27 is decoded as the 48-bit native maximum query.
// - The 28-bit answer comes from the true native maximum, never a limit.
// - The 48-bit answer comes from the true native maximum, never a limit.
// - In LBA mode a native maximum beyond 28 bits makes the 28-bit query give 0fffffff.
// - In LBA mode bits 7:0, 15:8, 23:16 go to sector, cyl low, cyl high.
// - In LBA mode bits 27:24 go to the head field.
// - With LBA clear the sector, cylinder and head of the maximum return.
// - Extended query, byte select clear: bits 7:0, 15:8, 23:16.
// - Extended query, byte select set: bits 31:24, 39:32, 47:40.
module native_max_address_query #(
  parameter int BUSY_LEN = `BUSY_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Command from the host
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic lba_mode_i,
  input wire logic high_order_byte_select_i,
  // Drive geometry and capacity limits
  input wire logic [47:0] native_max_lba_i,
  input wire native_max_pkg::chs_geometry_t native_max_chs_i,
  input wire logic [47:0] set_max_limit_i,
  input wire logic query_enable_i,
  // Answer to the host
  output native_max_pkg::task_file_out_t task_file_o,
  output logic [7:0] command_error_flags_o,
  output logic [7:0] command_status_flags_o,
  output logic done_o
);
  import native_max_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // One-hot pattern for a flag position in the status or error byte
  function automatic logic [7:0] flag_bit(input int pos);
    return 8'h01 << pos;
  endfunction

  // Every check below runs on this clock and sleeps through reset
  default clocking check_clk @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************
  // Decode
  // ****************************************
  wire is_query28 = cmd_code_i == `CMD_NATIVE_MAX_28;
  wire is_query48 = cmd_code_i == `CMD_NATIVE_MAX_48;
  wire start = cmd_write_i && (is_query28 || is_query48);

  // Limits are deliberately unread; the answer is the native maximum
  wire [47:0] true_max = native_max_lba_i;
  wire over28 = true_max > `LBA28_LIMIT;
  wire [27:0] lba28 = over28 ? `LBA28_SATURATED : true_max[27:0];

  wire task_file_out_t ans28_lba = '{
    sector_number: lba28[7:0],
    cylinder_low: lba28[15:8],
    cylinder_high: lba28[23:16],
    head: lba28[27:24]};
  wire task_file_out_t ans28_chs = '{
    sector_number: native_max_chs_i.sectors,
    cylinder_low: native_max_chs_i.cylinders[7:0],
    cylinder_high: native_max_chs_i.cylinders[15:8],
    head: native_max_chs_i.heads};
  wire task_file_out_t ans48_lo = '{
    sector_number: true_max[7:0],
    cylinder_low: true_max[15:8],
    cylinder_high: true_max[23:16],
    head: 4'h0};
  wire task_file_out_t ans48_hi = '{
    sector_number: true_max[31:24],
    cylinder_low: true_max[39:32],
    cylinder_high: true_max[47:40],
    head: 4'h0};

  wire task_file_out_t ans28 = lba_mode_i ? ans28_lba : ans28_chs;
  wire task_file_out_t ans48 = high_order_byte_select_i ? ans48_hi : ans48_lo;

  // ****************************************
  // Sequencer
  // ****************************************
  query_state_t state_reg, state_next;
  logic [7:0] busy_cnt_reg;
  logic is48_reg;
  logic reject_reg;
  task_file_out_t tf_reg;
  logic [7:0] err_reg;
  logic [7:0] st_reg;

  wire busy_over = busy_cnt_reg >= 8'(BUSY_LEN - 1);
  // A command is taken only from idle; writes while busy are ignored
  wire accept = (state_reg == ST_IDLE) && start;

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = start ? ST_BUSY : ST_IDLE;
      ST_BUSY: state_next = busy_over ? ST_DONE : ST_BUSY;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      busy_cnt_reg <= 8'h00;
      is48_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_cnt_reg <= (state_reg == ST_BUSY) ? busy_cnt_reg + 8'h01 : 8'h00;
      if (accept) begin
        is48_reg <= is_query48;
        reject_reg <= !query_enable_i;
      end
    end
  end

  // Byte select is applied when the answer is loaded at completion; the
  // host re-issues to read the other half
  wire finishing = state_reg == ST_BUSY && busy_over;
  wire [7:0] err_done = reject_reg ? flag_bit(`ERR_ABORT_BIT) : 8'h00;
  wire [7:0] st_done = flag_bit(`ST_READY_BIT) |
    (reject_reg ? flag_bit(`ST_ERROR_BIT) : 8'h00);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tf_reg <= '0;
      err_reg <= `ERROR_RESET;
      st_reg <= `STATUS_RESET;
    end else if (accept) begin
      st_reg <= flag_bit(`ST_BUSY_BIT);
      err_reg <= 8'h00;
    end else if (finishing) begin
      st_reg <= st_done;
      err_reg <= err_done;
      tf_reg <= reject_reg ? tf_reg : (is48_reg ? ans48 : ans28);
    end
  end

  assign task_file_o = tf_reg;
  assign command_error_flags_o = err_reg;
  assign command_status_flags_o = st_reg;
  assign done_o = state_reg == ST_DONE;

  // ****************************************
  // Checks
  // ****************************************
  // Plain slices of the inputs and of the answer, so the checks never lean on the datapath
  wire [7:0] lba_b0 = native_max_lba_i[7:0];
  wire [7:0] lba_b1 = native_max_lba_i[15:8];
  wire [7:0] lba_b2 = native_max_lba_i[23:16];
  wire [3:0] lba_h28 = native_max_lba_i[27:24];
  wire [7:0] lba_b3 = native_max_lba_i[31:24];
  wire [7:0] lba_b4 = native_max_lba_i[39:32];
  wire [7:0] lba_b5 = native_max_lba_i[47:40];
  wire [7:0] chs_sec = native_max_chs_i.sectors;
  wire [15:0] chs_cyl = native_max_chs_i.cylinders;
  wire [3:0] chs_head = native_max_chs_i.heads;
  wire [15:0] tf_cyl = {task_file_o.cylinder_high, task_file_o.cylinder_low};

  // Which kind of answer the completing edge loads
  wire load28 = finishing && !reject_reg && !is48_reg;
  wire load48 = finishing && !reject_reg && is48_reg;
  wire load_lba = load28 && lba_mode_i;
  wire load_chs = load28 && !lba_mode_i;
  wire load_reject = finishing && reject_reg;

  // Edges from the taking edge to the one that samples done high
  localparam int DONE_AT = BUSY_LEN + 1;

  // Length of the busy stretch as the host sees it; a counter, since
  // the stretch may be too long to spell out as a repetition
  logic [7:0] busy_run_reg;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_run_reg <= 8'h00;
    end else if (command_status_flags_o[`ST_BUSY_BIT]) begin
      busy_run_reg <= busy_run_reg + 8'h01;
    end else begin
      busy_run_reg <= 8'h00;
    end
  end

  sequence query_issued;
    accept;
  endsequence

  // A completion shows done for exactly one cycle
  sequence done_pulse;
    done_o ##1 !done_o;
  endsequence

  // Abort alone in the error byte; ready and error up in the status byte
  sequence reject_shown;
    command_error_flags_o == 8'h04 && command_status_flags_o == 8'h41;
  endsequence

  busy_on_start_a: assert property (
    query_issued |=> command_status_flags_o[`ST_BUSY_BIT])
    else $error("busy not raised after query");

  decode28_a: assert property (
    (query_issued and is_query28) |=> !is48_reg)
    else $error("short query code not decoded");

  decode48_a: assert property (
    (query_issued and is_query48) |=> is48_reg)
    else $error("extended code not decoded");

  unknown_ignored_a: assert property (
    state_reg == ST_IDLE && cmd_write_i && !is_query28 && !is_query48
    |=> $stable(command_status_flags_o))
    else $error("unknown command code taken");

  limit28_a: assert property (
    load_lba && !over28 && set_max_limit_i != native_max_lba_i
    |=> task_file_o.cylinder_high == $past(lba_b2)
    && task_file_o.cylinder_low == $past(lba_b1))
    else $error("short answer follows the limit");

  lba_bytes_a: assert property (
    load_lba && !over28 |=> task_file_o.sector_number == $past(lba_b0)
    && task_file_o.cylinder_low == $past(lba_b1)
    && task_file_o.cylinder_high == $past(lba_b2))
    else $error("lba bytes not in sector and cylinder fields");

  lba_head_a: assert property (
    load_lba && !over28 |=> task_file_o.head == $past(lba_h28))
    else $error("head field not lba bits 27:24");

  saturate_a: assert property (
    load_lba && over28 |=> task_file_o == 28'hfffffff)
    else $error("28-bit answer not saturated");

  chs_answer_a: assert property (
    load_chs |=> task_file_o.sector_number == $past(chs_sec))
    else $error("chs sector not returned");

  chs_geometry_a: assert property (
    load_chs |=> tf_cyl == $past(chs_cyl)
    && task_file_o.head == $past(chs_head))
    else $error("chs cylinder or head not returned");

  limit_ignored_a: assert property (
    load48 && !high_order_byte_select_i
    |=> task_file_o.sector_number == $past(lba_b0))
    else $error("extended answer not the native maximum");

  lower_half_a: assert property (
    load48 && !high_order_byte_select_i
    |=> task_file_o.cylinder_low == $past(lba_b1)
    && task_file_o.cylinder_high == $past(lba_b2))
    else $error("low half not bits 23:8");

  upper_half_a: assert property (
    load48 && high_order_byte_select_i
    |=> task_file_o.cylinder_high == $past(lba_b5))
    else $error("high half not bits 47:40");

  upper_bytes_a: assert property (
    load48 && high_order_byte_select_i
    |=> task_file_o.sector_number == $past(lba_b3)
    && task_file_o.cylinder_low == $past(lba_b4))
    else $error("high half not bits 39:24");

  abort_flags_a: assert property (
    load_reject |=> reject_shown ##1 !done_o)
    else $error("rejected query flags wrong");

  reject_keeps_a: assert property (
    load_reject |=> $stable(task_file_o))
    else $error("rejected query changed the answer");

  other_errors_a: assert property (
    (command_error_flags_o & 8'hfb) == 8'h00)
    else $error("error bit other than abort set");

  error_bit_a: assert property (
    command_status_flags_o[`ST_ERROR_BIT]
    == command_error_flags_o[`ERR_ABORT_BIT])
    else $error("status error bit disagrees with abort");

  fault_clear_a: assert property (
    !command_status_flags_o[`ST_FAULT_BIT]
    && !command_status_flags_o[`ST_DATA_REQUEST_BIT])
    else $error("fault or data request flag raised");

  busy_clears_a: assert property (
    done_o |-> !command_status_flags_o[`ST_BUSY_BIT]
    && command_status_flags_o[`ST_READY_BIT])
    else $error("busy not cleared at completion");

  busy_length_a: assert property (
    $fell(command_status_flags_o[`ST_BUSY_BIT])
    |-> busy_run_reg == 8'(BUSY_LEN))
    else $error("busy stretch has the wrong length");

  done_time_a: assert property (
    query_issued |-> ##[DONE_AT:DONE_AT] done_pulse)
    else $error("completion not signalled in time");

endmodule // native_max_address_query

// ===== bench/host_adapter_model.sv
// Host side model that writes the drive command register
`timescale 1ns/1ps
module host_adapter_model (
  // Clock
  input wire logic ref_clk_i,
  // Command to the drive
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o
);
  initial begin
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
  end
  // One-cycle strobe; code is scrambled once the taking edge has passed
  task automatic issue(input logic [7:0] code);
    @(negedge ref_clk_i);
    cmd_code_o = code;
    cmd_write_o = 1'b1;
    @(negedge ref_clk_i);
    cmd_write_o = 1'b0;
    cmd_code_o = ~code;
  endtask
endmodule // host_adapter_model

// ===== bench/native_max_address_query_tb.sv
// Self-checking bench for the native maximum address query block
`timescale 1ns/1ps
module native_max_address_query_tb;
  import native_max_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_write_i;
  logic [7:0] cmd_code_i;
  logic lba_mode_i = 1'b1;
  logic high_order_byte_select_i = 1'b0;
  logic [47:0] native_max_lba_i = 48'h0;
  chs_geometry_t native_max_chs_i = '0;
  logic [47:0] set_max_limit_i = 48'h0;
  logic query_enable_i = 1'b1;
  task_file_out_t task_file_o;
  logic [7:0] command_error_flags_o;
  logic [7:0] command_status_flags_o;
  logic done_o;
  int n_errors = 0;
  int samples_checked = 0;
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  host_adapter_model host_adapter_model_inst (
    .ref_clk_i(ref_clk_i),
    .cmd_write_o(cmd_write_i),
    .cmd_code_o(cmd_code_i)
  );
  native_max_address_query native_max_address_query_inst (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cmd_write_i(cmd_write_i),
    .cmd_code_i(cmd_code_i),
    .lba_mode_i(lba_mode_i),
    .high_order_byte_select_i(high_order_byte_select_i),
    .native_max_lba_i(native_max_lba_i),
    .native_max_chs_i(native_max_chs_i),
    .set_max_limit_i(set_max_limit_i),
    .query_enable_i(query_enable_i),
    .task_file_o(task_file_o),
    .command_error_flags_o(command_error_flags_o),
    .command_status_flags_o(command_status_flags_o),
    .done_o(done_o)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [43:0] got, input logic [43:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Issue, see busy, wait a bounded time for done, compare the answer
  task automatic query(input logic [7:0] code, input logic [43:0] exp);
    int i;
    host_adapter_model_inst.issue(code);
    check({36'h0, command_status_flags_o}, {36'h0, 8'h80});
    i = 0;
    while (done_o !== 1'b1 && i < 20) begin
      @(negedge ref_clk_i);
      i++;
    end
    if (i >= 20) begin
      n_errors++;
      $display("mismatch at %0t: no completion seen", $time);
    end
    check({task_file_o, command_error_flags_o, command_status_flags_o}, exp);
    @(negedge ref_clk_i);
    check({43'h0, done_o}, 44'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_unknown();
    host_adapter_model_inst.issue(8'h20);
    check({36'h0, command_status_flags_o}, {36'h0, 8'h40});
    repeat (6) @(negedge ref_clk_i);
    check({28'h0, command_error_flags_o, command_status_flags_o},
      {28'h0, 8'h00, 8'h40});
    $display("test unknown done");
  endtask
  task automatic test_lba28();
    native_max_lba_i = 48'h000009abcdef;
    set_max_limit_i = 48'h000000001000;
    query(8'hf8, {8'hef, 8'hcd, 8'hab, 4'h9, 8'h00, 8'h40});
    native_max_lba_i = 48'h123456789abc;
    query(8'hf8, {8'hff, 8'hff, 8'hff, 4'hf, 8'h00, 8'h40});
    $display("test lba28 done");
  endtask
  task automatic test_chs();
    lba_mode_i = 1'b0;
    native_max_chs_i = '{cylinders: 16'h3fff, heads: 4'he, sectors: 8'h3f};
    query(8'hf8, {8'h3f, 8'hff, 8'h3f, 4'he, 8'h00, 8'h40});
    lba_mode_i = 1'b1;
    $display("test chs done");
  endtask
  task automatic test_ext();
    set_max_limit_i = 48'h000000100000;
    query(8'h27, {8'hbc, 8'h9a, 8'h78, 4'h0, 8'h00, 8'h40});
    high_order_byte_select_i = 1'b1;
    query(8'h27, {8'h56, 8'h34, 8'h12, 4'h0, 8'h00, 8'h40});
    $display("test ext done");
  endtask
  task automatic test_reject();
    query_enable_i = 1'b0;
    query(8'hf8, {8'h56, 8'h34, 8'h12, 4'h0, 8'h04, 8'h41});
    query_enable_i = 1'b1;
    $display("test reject done");
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_i = 1'b0;
    test_unknown();
    test_lba28();
    test_chs();
    test_ext();
    test_reject();
    end_sim();
  end
  // Six queries of about eight cycles each fit well inside this span
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
endmodule // native_max_address_query_tb
